// file: hw/dcr_defines.svh
/*
  Constants for the decimating converter readout block.
  Assumes inclusion by bare name from any design file.
*/
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

`define DCR_RES_W        24
`define DCR_CFG_W        8
`define DCR_FRAME_W      32
`define DCR_DIFF_W       14
`define DCR_CM_W         8
`define DCR_NL_W         22
`define DCR_CFG_DF4      8'h26
`define DCR_CFG_DF8      8'h36
`define DCR_CFG_DF16     8'h46
`define DCR_CFG_DF32     8'h56
`define DCR_CONV_NS      500
`define DCR_CLK_NS       10
`define DCR_CONV_CYC     ((`DCR_CONV_NS + `DCR_CLK_NS - 1) / `DCR_CLK_NS)
`define DCR_SETTLE_OUT   35

`endif

// file: hw/dcr_pkg.sv
/*
  Types for the decimating converter readout block.
  Assumes dcr_defines.svh sits on the include path.
*/
`include "dcr_defines.svh"
package dcr_pkg;
  // Composite no-latency code: differential part then common mode
  typedef struct packed {
    logic [`DCR_DIFF_W-1:0] diff;
    logic [`DCR_CM_W-1:0]   cm;
  } dcr_nl_s;

  // One serial output pin with its enable
  typedef struct packed {
    logic data;
    logic oe;
  } dcr_pin_s;

  typedef enum logic [1:0] {
    DCR_IDLE,
    DCR_CONV
  } dcr_state_e;
endpackage : dcr_pkg

// file: hw/dcr_readout.sv
/*
  Digital output side of a decimating converter: conversion timing, down-sampler
  with sync alignment, and two serial readout ports.
  Assumes the filter datapath supplies one filtered word and one composite code
  per conversion; serial clocks, read enables, master clock and sync arrive
  asynchronously and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcr_defines.svh"

// Notes on behaviour
// - Result register refreshed once per DF conversions
// - Ready strobe high during every DF-th conversion
// - Result readable bit by bit across conversions
// - Updates at DF multiples counted from sync
// - In-phase sync leaves operation undisturbed
// - Out-of-phase sync realigns within one conversion
// - Phase-changing sync resets filter state
// - No-latency register loaded every conversion
// - Composite shifted diff MSB first, then CM
// - Config word follows result, 32-bit frame
// - Config word encodes active decimation factor
// - Enable low: result MSB after strobe falls
// - Enable falling edge presents result MSB
// - No-latency MSB after busy falls, on enable
// - Output settles within 35 output samples
// - Straps select DF 4, 8, 16, 32
// - Down-sampler keeps one in DF samples
module dcr_readout #(
  parameter int CONV_CYC = `DCR_CONV_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   master_clock,
  input  wire logic                   sync_in,
  input  wire logic                   decim_select_hi,
  input  wire logic                   decim_select_lo,
  input  wire logic [`DCR_RES_W-1:0]  filter_word,
  input  wire dcr_pkg::dcr_nl_s       nolatency_code,
  input  wire logic                   filtered_serial_clock,
  input  wire logic                   nolatency_serial_clock,
  input  wire logic                   filtered_read_enable_n,
  input  wire logic                   nolatency_read_enable_n,
  output logic                        busy,
  output logic                        filtered_ready_strobe,
  output logic                        filter_clear,
  output logic                        settled,
  output dcr_pkg::dcr_pin_s           filtered_serial_out,
  output dcr_pkg::dcr_pin_s           nolatency_serial_out
);
  import dcr_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 6;
  logic [NS-1:0] sy1_reg, sy2_reg, sy3_reg;
  logic [NS-1:0] sy_raw;
  assign sy_raw = {master_clock, sync_in, filtered_serial_clock,
                   nolatency_serial_clock, filtered_read_enable_n, nolatency_read_enable_n};

  // Two stages per pin, third stage only for edge detection
  // Enables reset to their idle high level: no false fall and no drive after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sy1_reg <= 6'h03;
      sy2_reg <= 6'h03;
      sy3_reg <= 6'h03;
    end else begin
      sy1_reg <= sy_raw;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  logic mclk_rise, sync_rise, sck_a_rise, sck_b_rise, ren_a_fall, ren_b_fall;
  logic ren_a_n, ren_b_n;
  assign mclk_rise  = sy2_reg[5] & ~sy3_reg[5];
  assign sync_rise  = sy2_reg[4] & ~sy3_reg[4];
  assign sck_a_rise = sy2_reg[3] & ~sy3_reg[3];
  assign sck_b_rise = sy2_reg[2] & ~sy3_reg[2];
  assign ren_a_n    = sy2_reg[1];
  assign ren_b_n    = sy2_reg[0];
  assign ren_a_fall = ~sy2_reg[1] & sy3_reg[1];
  assign ren_b_fall = ~sy2_reg[0] & sy3_reg[0];

  // ----------------------------------------------------------------
  // Decimation factor from straps
  // ----------------------------------------------------------------
  logic [5:0] df_val;
  logic [7:0] cfg_word;
  // Straps are static; read them directly rather than latching at reset
  always_comb begin
    unique case ({decim_select_hi, decim_select_lo})
      2'b00: begin df_val = 6'd4;  cfg_word = `DCR_CFG_DF4;  end
      2'b01: begin df_val = 6'd8;  cfg_word = `DCR_CFG_DF8;  end
      2'b10: begin df_val = 6'd16; cfg_word = `DCR_CFG_DF16; end
      2'b11: begin df_val = 6'd32; cfg_word = `DCR_CFG_DF32; end
    endcase
  end

  // ----------------------------------------------------------------
  // Conversion timing and down-sampler phase
  // ----------------------------------------------------------------
  dcr_state_e       st_reg, st_next;
  logic [15:0]      cyc_reg, cyc_next;
  logic [5:0]       ph_reg, ph_next;
  logic             drl_reg, drl_next;
  logic             clr_reg, clr_next;
  logic [`DCR_RES_W-1:0] res_reg, res_next;
  dcr_nl_s          nl_reg, nl_next;
  logic [5:0]       outs_reg, outs_next;
  logic             conv_done;

  assign conv_done = (st_reg == DCR_CONV) && (cyc_reg == 16'(CONV_CYC - 1));

  // Phase counts conversions; zero marks the DF-th conversion
  always_comb begin
    st_next   = st_reg;
    cyc_next  = cyc_reg;
    ph_next   = ph_reg;
    drl_next  = drl_reg;
    clr_next  = 1'b0;
    res_next  = res_reg;
    nl_next   = nl_reg;
    outs_next = outs_reg;
    if (sync_rise && ph_reg != 6'd0) begin
      ph_next  = 6'd0;
      clr_next = 1'b1;
      outs_next = 6'd0;
    end                                                 // in phase, nothing changes
    unique case (st_reg)
      DCR_IDLE: begin
        if (mclk_rise) begin
          st_next  = DCR_CONV;
          cyc_next = 16'd0;
          drl_next = (ph_next == 6'd0);
        end
      end
      DCR_CONV: begin
        cyc_next = cyc_reg + 16'd1;
        if (conv_done) begin
          st_next  = DCR_IDLE;
          drl_next = 1'b0;
          nl_next  = nolatency_code;
          if (ph_reg == 6'd0 && !clr_next) begin
            res_next = filter_word;
            if (outs_reg != 6'(`DCR_SETTLE_OUT))
              outs_next = outs_reg + 6'd1;
          end
          if (!clr_next)
            ph_next = (ph_reg == df_val - 6'd1) ? 6'd0 : ph_reg + 6'd1;
        end
      end
      default: st_next = DCR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg   <= DCR_IDLE;
      cyc_reg  <= '0;
      ph_reg   <= '0;
      drl_reg  <= 1'b0;
      clr_reg  <= 1'b0;
      res_reg  <= '0;
      nl_reg   <= '0;
      outs_reg <= '0;
    end else begin
      st_reg   <= st_next;
      cyc_reg  <= cyc_next;
      ph_reg   <= ph_next;
      drl_reg  <= drl_next;
      clr_reg  <= clr_next;
      res_reg  <= res_next;
      nl_reg   <= nl_next;
      outs_reg <= outs_next;
    end
  end

  assign busy                  = (st_reg == DCR_CONV);
  assign filtered_ready_strobe = drl_reg;
  assign filter_clear          = clr_reg;
  assign settled               = (outs_reg == 6'(`DCR_SETTLE_OUT));

  // ----------------------------------------------------------------
  // Serial shifters
  // ----------------------------------------------------------------
  logic [`DCR_FRAME_W-1:0] sha_reg, sha_next;
  logic [`DCR_NL_W-1:0]    shb_reg, shb_next;
  logic                    load_a, load_b;

  // Reload the frame only on a new result or an enable fall so a partial read restarts at the MSB; a
  // distributed read keeps its position while its enable stays low, since only a new result then reloads
  assign load_a = (conv_done && ph_reg == 6'd0 && !clr_next) || ren_a_fall;
  assign load_b = conv_done || ren_b_fall;

  always_comb begin
    sha_next = sha_reg;
    shb_next = shb_reg;
    if (load_a)
      sha_next = {res_next, cfg_word};
    else if (sck_a_rise && !ren_a_n && !busy)
      sha_next = {sha_reg[`DCR_FRAME_W-2:0], 1'b0};
    if (load_b)
      shb_next = nl_next;
    else if (sck_b_rise && !ren_b_n && !busy)
      shb_next = {shb_reg[`DCR_NL_W-2:0], 1'b0};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sha_reg <= '0;
      shb_reg <= '0;
    end else begin
      sha_reg <= sha_next;
      shb_reg <= shb_next;
    end
  end

  // Released while enable high so other converters can share the line
  assign filtered_serial_out.data  = sha_reg[`DCR_FRAME_W-1];
  assign filtered_serial_out.oe    = ~ren_a_n;
  assign nolatency_serial_out.data = shb_reg[`DCR_NL_W-1];
  assign nolatency_serial_out.oe   = ~ren_b_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_conv_end;
    conv_done && ph_reg == 6'd0 && !clr_next;
  endsequence

  // A fresh result reaches the pin at once when its enable already stands low
  sequence s_result_shown;
    s_conv_end ##1 !ren_a_n;
  endsequence

  sequence s_code_shown;
    conv_done ##1 !ren_b_n;
  endsequence

  // Down-sampler, strobe and conversion length
  a_result_hold: assert property (@(posedge clk) disable iff (rst)
    ph_reg != 6'd0 |=> $stable(res_reg))
    else $error("result changed off phase");
  a_update_phase: assert property (@(posedge clk) disable iff (rst)
    $changed(res_reg) |-> $past(conv_done) && $past(ph_reg) == 6'd0)
    else $error("result updated outside the kept sample");
  a_strobe_drop: assert property (@(posedge clk) disable iff (rst)
    conv_done |=> !drl_reg)
    else $error("strobe not dropped at conversion end");
  a_strobe_phase: assert property (@(posedge clk) disable iff (rst)
    $rose(drl_reg) |-> $past(ph_next) == 6'd0 && busy)
    else $error("strobe raised off phase");
  a_strobe_busy: assert property (@(posedge clk) disable iff (rst)
    filtered_ready_strobe |-> busy)
    else $error("strobe high outside a conversion");
  a_busy_cap: assert property (@(posedge clk) disable iff (rst)
    busy |-> cyc_reg < 16'(CONV_CYC))
    else $error("conversion ran past its length");
  // Sync alignment and filter clear
  a_sync_align: assert property (@(posedge clk) disable iff (rst)
    (sync_rise && ph_reg != 6'd0) |=> ph_reg == 6'd0 && clr_reg)
    else $error("sync did not realign");
  a_sync_quiet: assert property (@(posedge clk) disable iff (rst)
    (sync_rise && ph_reg == 6'd0) |=> !clr_reg)
    else $error("in-phase sync disturbed filter");
  a_realign_one: assert property (@(posedge clk) disable iff (rst)
    clr_reg |-> ph_reg == 6'd0)
    else $error("clear without phase reset");
  a_clear_cause: assert property (@(posedge clk) disable iff (rst)
    filter_clear |-> $past(sync_rise) && $past(ph_reg) != 6'd0)
    else $error("filter cleared without a phase change");
  // Serial ports and settle count
  a_nl_load: assert property (@(posedge clk) disable iff (rst)
    conv_done |=> nl_reg == $past(nolatency_code))
    else $error("no-latency code not loaded");
  a_frame_load: assert property (@(posedge clk) disable iff (rst)
    s_conv_end |=> sha_reg == {res_reg, cfg_word})
    else $error("frame not loaded");
  a_ready_msb: assert property (@(posedge clk) disable iff (rst)
    s_result_shown |-> filtered_serial_out.data == res_reg[`DCR_RES_W-1])
    else $error("result msb not shown after update");
  a_msb_enable: assert property (@(posedge clk) disable iff (rst)
    ren_a_fall |=> filtered_serial_out.data == res_reg[`DCR_RES_W-1])
    else $error("msb not presented on enable");
  a_nl_ready: assert property (@(posedge clk) disable iff (rst)
    s_code_shown |-> nolatency_serial_out.data == nl_reg.diff[`DCR_DIFF_W-1])
    else $error("no-latency msb not shown after conversion");
  a_nl_msb: assert property (@(posedge clk) disable iff (rst)
    ren_b_fall |=> nolatency_serial_out.data == nl_reg.diff[`DCR_DIFF_W-1])
    else $error("no-latency msb not presented");
  a_release: assert property (@(posedge clk) disable iff (rst)
    $past(filtered_read_enable_n, 2) |-> !filtered_serial_out.oe)
    else $error("driving while disabled");
  a_release_b: assert property (@(posedge clk) disable iff (rst)
    $past(nolatency_read_enable_n, 2) |-> !nolatency_serial_out.oe)
    else $error("no-latency line driven while disabled");
  a_settle_cap: assert property (@(posedge clk) disable iff (rst)
    outs_reg <= 6'(`DCR_SETTLE_OUT))
    else $error("settle count overran");
endmodule : dcr_readout

`default_nettype wire

// file: testbench/dcr_host_model.sv
/*
  Host reader model for the filtered and no-latency serial ports.
  Assumes the bench calls its tasks only between conversions.
*/
`timescale 1ns/100ps
`default_nettype none
module dcr_host_model (
  input  wire dcr_pkg::dcr_pin_s filtered_serial_out,
  input  wire dcr_pkg::dcr_pin_s nolatency_serial_out,
  input  wire logic              busy,
  output logic                   filtered_serial_clock,
  output logic                   nolatency_serial_clock,
  output logic                   filtered_read_enable_n,
  output logic                   nolatency_read_enable_n
);
  import dcr_pkg::*;
  localparam realtime HALF = 62.5;
  // A released line floats, so it can never pass for a driven bit
  wire line_a = filtered_serial_out.oe ? filtered_serial_out.data : 1'bz;
  wire line_b = nolatency_serial_out.oe ? nolatency_serial_out.data : 1'bz;
  // Clocks stand low outside frames, enables idle high
  initial begin
    filtered_serial_clock = 1'b0;
    nolatency_serial_clock = 1'b0;
    filtered_read_enable_n = 1'b1;
    nolatency_read_enable_n = 1'b1;
  end
  // Enables move only while idle; the bench lowers one at a time
  task automatic enable(input logic sel_b, input logic val_n);
    wait (busy === 1'b0);
    if (sel_b) nolatency_read_enable_n = val_n;
    else filtered_read_enable_n = val_n;
    #(2 * HALF);
  endtask : enable
  // Sample before the rising edge, then one full link clock period
  task automatic shift(input logic sel_b, output logic bit_v);
    bit_v = sel_b ? line_b : line_a;
    if (sel_b) nolatency_serial_clock = 1'b1;
    else filtered_serial_clock = 1'b1;
    #HALF;
    nolatency_serial_clock = 1'b0;
    filtered_serial_clock = 1'b0;
    #HALF;
  endtask : shift
endmodule : dcr_host_model
`default_nettype wire

// file: testbench/tb_decimating_adc_dual_serial_readout.sv
/*
  Self-checking bench for the converter readout block.
  Assumes dcr_pkg and dcr_host_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_decimating_adc_dual_serial_readout;
  import dcr_pkg::*;
  localparam int CONV = 4;
  logic clk, rst, master_clock, sync_in, decim_select_hi, decim_select_lo;
  logic busy, filtered_ready_strobe, filter_clear, settled, strobe, b, full, burst;
  logic filtered_serial_clock, nolatency_serial_clock;
  logic filtered_read_enable_n, nolatency_read_enable_n;
  logic [23:0] filter_word;
  logic [31:0] frame;
  logic [21:0] nl_got;
  dcr_nl_s  nolatency_code;
  dcr_pin_s filtered_serial_out, nolatency_serial_out;
  int fail_count = 0, checks = 0, clears = 0, df, idx, ref_i, k;
  dcr_readout #(.CONV_CYC(CONV)) i_dut (.clk, .rst, .master_clock, .sync_in,
    .decim_select_hi, .decim_select_lo, .filter_word, .nolatency_code,
    .filtered_serial_clock, .nolatency_serial_clock, .filtered_read_enable_n,
    .nolatency_read_enable_n, .busy, .filtered_ready_strobe, .filter_clear,
    .settled, .filtered_serial_out, .nolatency_serial_out);
  dcr_host_model i_host (.filtered_serial_out, .nolatency_serial_out, .busy,
    .filtered_serial_clock, .nolatency_serial_clock, .filtered_read_enable_n,
    .nolatency_read_enable_n);
  // ----------------------------------------
  // Clock, clear-pulse counter and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counting pulses keeps a one-cycle clear from slipping past unseen
  always @(posedge clk) if (filter_clear === 1'b1) clears <= clears + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Bounded wait; a hang shows up as a mismatch on busy
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 40 && busy !== lvl; n++) begin
      @(posedge clk);
      #1;
    end
    chk(busy, lvl);
  endtask : wait_busy
  // One conversion with fresh random datapath words
  task automatic conv(output logic strb);
    @(posedge clk);
    filter_word <= 24'($urandom);
    nolatency_code <= 22'($urandom);
    master_clock <= 1'b1;
    wait_busy(1'b1);
    @(posedge clk);
    #1;
    strb = filtered_ready_strobe;
    wait_busy(1'b0);
    chk(filtered_ready_strobe, 1'b0);
    @(posedge clk);
    master_clock <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : conv
  // Sync pulse between conversions; exp_clr below zero means either
  task automatic sync_pulse(input int exp_clr);
    int c0;
    c0 = clears;
    @(posedge clk);
    sync_in <= 1'b1;
    repeat (4) @(posedge clk);
    sync_in <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    if (exp_clr >= 0) chk(clears - c0, exp_clr);
    if (exp_clr == 1) chk(settled, 1'b0);
  endtask : sync_pulse
  // First edge after reset release: outputs quiet and both lines released
  task automatic quiet_check();
    @(posedge clk);
    #1;
    chk({busy, filtered_ready_strobe, filter_clear, settled, filtered_serial_out.oe,
         nolatency_serial_out.oe}, 32'h0);
  endtask : quiet_check
  // Configuration word expected for each strap code
  function automatic logic [7:0] cfg_exp(input int code);
    case (code)
      0: return 8'h26;
      1: return 8'h36;
      2: return 8'h46;
      default: return 8'h56;
    endcase
  endfunction : cfg_exp
  // ----------------------------------------
  // Main sequence: every strap code in turn
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {master_clock, sync_in, decim_select_hi, decim_select_lo, full} = '0;
    filter_word = '0;
    nolatency_code = '0;
    void'($urandom(67558));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    quiet_check();
    for (int c = 0; c < 4; c++) begin
      df = 4 << c;
      @(posedge clk);
      {decim_select_hi, decim_select_lo} <= 2'(c);
      sync_pulse(-1);
      ref_i = -1;
      idx = 0;
      k = 32;
      for (int n = 0; n < 3 * df + 2; n++) begin
        if (n == df) sync_pulse(0);
        if (n == 2 * df + 1) sync_pulse(1);
        if (n == 2 * df + 1) ref_i = -1;
        if (n == df || n == 2 * df + 1) idx = 0;
        conv(strobe);
        idx++;
        burst = 1'b0;
        if (strobe === 1'b1) begin
          if (ref_i < 0) ref_i = idx % df;
          chk(idx % df, ref_i);
          if (filtered_read_enable_n === 1'b0) chk(filtered_serial_out, {filter_word[23], 1'b1});
          i_host.enable(1'b0, 1'b1);
          chk(filtered_serial_out.oe, 1'b0);
          i_host.enable(1'b1, 1'b0);
          for (int j = 21; j >= 0; j--) i_host.shift(1'b1, nl_got[j]);
          i_host.enable(1'b1, 1'b1);
          chk(nl_got, nolatency_code);
          i_host.enable(1'b0, 1'b0);
          frame = {filter_word, cfg_exp(c)};
          k = 0;
          full = ~full;
          burst = full;
        end
        if (ref_i < 0) chk(idx > df, 1'b0);
        for (int j = 0; j < (burst ? 32 : 1) && k < 32; j++) begin
          i_host.shift(1'b0, b);
          chk(b, frame[31 - k]);
          k++;
        end
      end
    end
    // Mid-run reset, then count outputs up to the settling mark
    @(posedge clk);
    rst <= 1'b1;
    {decim_select_hi, decim_select_lo} <= 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    quiet_check();
    idx = 0;
    for (int n = 0; n < 4 * 36; n++) begin
      conv(strobe);
      chk(strobe, n % 4 == 0);
      if (strobe === 1'b1) idx++;
      chk(settled, idx >= 35);
    end
    results();
  end
  // Watchdog at about three times the expected run length
  initial begin
    #500_000;
    fail_count++;
    results();
  end
endmodule : tb_decimating_adc_dual_serial_readout
`default_nettype wire
